//--- asc_pkg.sv
// package: pin map, timing and request types for the async sram host controller
// Function
// - host holds write data valid around the edge of the control ending the write
// - host never drives data pins while the device may be driving them
// - host keeps lane enables steady while the chip is deselected
// - host holds write enable high throughout every read
// - host presents a valid address no later than selects and lane enables activate
package asc_pkg;
  localparam int ASC_AW = 20;
  localparam int ASC_DW = 16;
  localparam int ASC_LANES = 2;
  // times in ns, cycle counts rounded up for a 4 ns clock
  localparam int ASC_CLK_NS = 4;
  localparam int ASC_T_RC_NS = 45;   // read cycle, also address to data
  localparam int ASC_T_PWE_NS = 35;  // write pulse width
  localparam int ASC_T_SD_NS = 25;   // data setup to write end
  localparam int ASC_T_HZ_NS = 18;   // output turn off after oe high
  localparam int ASC_T_WC_NS = 45;   // write cycle
  localparam int ASC_RD_CYC = (ASC_T_RC_NS + ASC_CLK_NS - 1) / ASC_CLK_NS;
  localparam int ASC_WR_CYC = (ASC_T_PWE_NS + ASC_CLK_NS - 1) / ASC_CLK_NS;
  localparam int ASC_HZ_CYC = (ASC_T_HZ_NS + ASC_CLK_NS - 1) / ASC_CLK_NS;
  localparam int ASC_REC_CYC = (ASC_T_WC_NS - ASC_T_PWE_NS + ASC_CLK_NS - 1) / ASC_CLK_NS;
  localparam int ASC_CW = 5;
  localparam logic [ASC_CW-1:0] ASC_CNT_ZERO = 5'h00;
  localparam logic [ASC_CW-1:0] ASC_CNT_ONE = 5'h01;

  // control pins as seen at the device, active levels per pin
  typedef struct packed {
    logic select_active_low;
    logic select_active_high;
    logic write_en_n;
    logic output_en_n;
    logic upper_lane_en_n;
    logic lower_lane_en_n;
  } asc_ctl_t;

  localparam asc_ctl_t ASC_CTL_IDLE = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

  // one host request
  typedef struct packed {
    logic write;
    logic [ASC_AW-1:0] addr;
    logic [ASC_LANES-1:0] lanes;  // bit1 upper, bit0 lower, active high
    logic [ASC_DW-1:0] wdata;
  } asc_req_t;

  typedef enum logic [2:0] {
    ASC_IDLE,
    ASC_RD,
    ASC_RD_OFF,
    ASC_WR,
    ASC_WR_END,
    ASC_REC
  } asc_state_t;
endpackage

//--- asc_host.sv
// host controller driving an asynchronous sram through its pins
`timescale 1ns/10ps
module asc_host
  import asc_pkg::*;
#(
  // bus widths; the lanes are always two, each DW/2 bits wide
  parameter int AW = ASC_AW,
  parameter int DW = ASC_DW,
  // phase lengths in clocks; the counter is ASC_CW bits wide
  parameter int RD_CYC = ASC_RD_CYC,
  parameter int WR_CYC = ASC_WR_CYC,
  parameter int HZ_CYC = ASC_HZ_CYC,
  parameter int REC_CYC = ASC_REC_CYC
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // request side
  input wire logic i_req_valid,
  input wire asc_req_t i_req,
  output logic o_req_ready,
  output logic o_rd_valid,
  output logic [DW-1:0] o_rd_data,
  // sram pins
  output asc_ctl_t o_ctl,
  output logic [AW-1:0] o_addr,
  output logic [DW-1:0] o_dq_out,
  output logic [DW-1:0] o_dq_oe,
  input wire logic [DW-1:0] i_dq_in
);
  // sequencer and phase counter
  asc_state_t st_q, st_d;
  logic [ASC_CW-1:0] cnt_q, cnt_d;
  // registered pins
  asc_ctl_t ctl_q, ctl_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [DW-1:0] dout_q, dout_d;
  logic [DW-1:0] oe_q, oe_d;
  logic [ASC_LANES-1:0] lanes_q, lanes_d;
  // request handshake and read return
  logic rdy_q, rdy_d;
  logic rv_q, rv_d;
  logic [DW-1:0] rdat_q, rdat_d;
  logic [DW-1:0] lane_mask;

  // widen lane enables to a per-bit mask
  assign lane_mask = {{(DW/2){lanes_q[1]}}, {(DW/2){lanes_q[0]}}};

  // access plan; every pin is registered so the sram never sees a decode glitch
  // read, from the take edge:
  //   address, both selects, the chosen lanes and output enable go active
  //   together, so the address is never late against the selects;
  //   RD_CYC clocks later (default 12, 48 ns) the data is sampled, the pins
  //   return to idle in one step and o_rd_valid pulses for one clock;
  //   then HZ_CYC clocks pass with the bus untouched, long enough for the
  //   sram to release its drivers before we may be asked to drive them
  // write, from the take edge:
  //   address, both selects, the chosen lanes and write enable go active
  //   with the data, and only the chosen lanes are driven;
  //   write enable rises alone after WR_CYC clocks (default 9, 36 ns), so the
  //   end of the write is always that one edge and the data stands across it;
  //   one clock later the pins idle and our drivers switch off together,
  //   then REC_CYC clocks fill out the rest of the write cycle
  // output enable stays high through every write: the sram can then never
  // fight our drivers, whatever the skew between its enables
  // a request with no lane chosen would never start an access at the sram,
  // so it is left untaken and ready stays high
  // limitation: the phase lengths assume a 4 ns clock and the counter holds
  // at most 31, so recompute them for any other clock
  // lanes that were not chosen read back as zero, since those pins float
  // and may show any level when sampled
  // sequencer next state
  always_comb begin
    st_d = st_q;
    ctl_d = ctl_q;
    addr_d = addr_q;
    dout_d = dout_q;
    oe_d = oe_q;
    cnt_d = cnt_q;
    lanes_d = lanes_q;
    rdy_d = rdy_q;
    rv_d = 1'b0;
    rdat_d = rdat_q;
    case (st_q)
      ASC_IDLE: begin
        if (i_req_valid && rdy_q && (i_req.lanes != 2'h0)) begin
          // address goes out with the selects, never after them
          addr_d = i_req.addr;
          lanes_d = i_req.lanes;
          rdy_d = 1'b0;
          ctl_d.select_active_low = 1'b0;
          ctl_d.select_active_high = 1'b1;
          // lanes only move together with the selects, going active here and idle at the end of the access
          ctl_d.upper_lane_en_n = ~i_req.lanes[1];
          ctl_d.lower_lane_en_n = ~i_req.lanes[0];
          if (i_req.write) begin
            // oe stays high so the device never drives while we do
            ctl_d.output_en_n = 1'b1;
            ctl_d.write_en_n = 1'b0;
            dout_d = i_req.wdata;
            oe_d = {{(DW/2){i_req.lanes[1]}}, {(DW/2){i_req.lanes[0]}}};
            cnt_d = ASC_CW'(WR_CYC);
            st_d = ASC_WR;
          end else begin
            ctl_d.write_en_n = 1'b1;
            ctl_d.output_en_n = 1'b0;
            oe_d = '0;
            cnt_d = ASC_CW'(RD_CYC);
            st_d = ASC_RD;
          end
        end
      end
      ASC_RD: begin
        // pins stand for the whole access time
        if (cnt_q == ASC_CNT_ONE) begin
          // keep only the lanes we enabled
          rdat_d = i_dq_in & lane_mask;
          rv_d = 1'b1;
          ctl_d = ASC_CTL_IDLE;
          cnt_d = ASC_CW'(HZ_CYC);
          st_d = ASC_RD_OFF;
        end else begin
          cnt_d = cnt_q - ASC_CNT_ONE;
        end
      end
      ASC_RD_OFF: begin
        // wait for the device to release the bus before we may drive it
        if (cnt_q == ASC_CNT_ONE) begin
          rdy_d = 1'b1;
          st_d = ASC_IDLE;
        end else begin
          cnt_d = cnt_q - ASC_CNT_ONE;
        end
      end
      ASC_WR: begin
        // write enable held low for the pulse width
        if (cnt_q == ASC_CNT_ONE) begin
          // write enable alone ends the write; data held one more cycle
          ctl_d.write_en_n = 1'b1;
          st_d = ASC_WR_END;
        end else begin
          cnt_d = cnt_q - ASC_CNT_ONE;
        end
      end
      ASC_WR_END: begin
        // data and lanes stay valid across the terminating edge, then release
        oe_d = '0;
        ctl_d = ASC_CTL_IDLE;
        cnt_d = ASC_CW'(REC_CYC);
        st_d = ASC_REC;
      end
      ASC_REC: begin
        // pins idle until the write cycle time is filled
        if (cnt_q <= ASC_CNT_ONE) begin
          rdy_d = 1'b1;
          st_d = ASC_IDLE;
        end else begin
          cnt_d = cnt_q - ASC_CNT_ONE;
        end
      end
      default: begin
        st_d = ASC_IDLE;
      end
    endcase
  end

  // register everything; reset parks the sram deselected with pins released
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st_q <= ASC_IDLE;
      ctl_q <= ASC_CTL_IDLE;
      addr_q <= '0;
      dout_q <= '0;
      oe_q <= '0;
      cnt_q <= ASC_CNT_ZERO;
      lanes_q <= '0;
      rdy_q <= 1'b1;
      rv_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      st_q <= st_d;
      ctl_q <= ctl_d;
      addr_q <= addr_d;
      dout_q <= dout_d;
      oe_q <= oe_d;
      cnt_q <= cnt_d;
      lanes_q <= lanes_d;
      rdy_q <= rdy_d;
      rv_q <= rv_d;
      rdat_q <= rdat_d;
    end
  end

  // every output is a flop wired straight to the pin
  assign o_req_ready = rdy_q;
  assign o_rd_valid = rv_q;
  assign o_rd_data = rdat_q;
  assign o_ctl = ctl_q;
  assign o_addr = addr_q;
  assign o_dq_out = dout_q;
  assign o_dq_oe = oe_q;
endmodule // asc_host

//--- asc_sram_model.sv
// behavioural byte-lane async sram partner
`timescale 1ns/10ps
module asc_sram_model
  import asc_pkg::*;
(
  input wire logic i_clk,
  input wire asc_ctl_t i_ctl,
  input wire logic [ASC_AW-1:0] i_addr,
  input wire logic [ASC_DW-1:0] i_dq,
  output logic [ASC_DW-1:0] o_dq,
  output logic [ASC_DW-1:0] o_drv
);
  // only sixteen words kept, upper address bits ignored to stay small
  logic [ASC_DW-1:0] mem [16];
  logic [ASC_DW-1:0] msk;
  logic sel;
  logic wr;
  initial for (int j = 0; j < 16; j++) mem[j] = 16'h0000;
  assign msk = {{8{!i_ctl.upper_lane_en_n}}, {8{!i_ctl.lower_lane_en_n}}};
  assign sel = !i_ctl.select_active_low && i_ctl.select_active_high && msk != 16'h0000;
  assign wr = sel && !i_ctl.write_en_n;
  // no drive in writes or with output off
  assign o_drv = (sel && !wr && !i_ctl.output_en_n) ? msk : 16'h0000;
  assign o_dq = mem[i_addr[3:0]];
  // store enabled lanes while the overlap lasts
  always @(posedge i_clk) if (wr) mem[i_addr[3:0]] <= (o_dq & ~msk) | (i_dq & msk);
endmodule  // asc_sram_model

//--- asc_host_checker.sv
// pin assertions for the host controller
`timescale 1ns/10ps
module asc_host_checker
  import asc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_req_valid,
  input wire asc_req_t i_req,
  input wire logic o_req_ready,
  input wire logic o_rd_valid,
  input wire logic [ASC_DW-1:0] o_rd_data,
  input wire asc_ctl_t o_ctl,
  input wire logic [ASC_AW-1:0] o_addr,
  input wire logic [ASC_DW-1:0] o_dq_out,
  input wire logic [ASC_DW-1:0] o_dq_oe,
  input wire logic [ASC_DW-1:0] i_dq_in
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  logic tk;
  assign tk = i_req_valid && o_req_ready && i_req.lanes != 2'h0;
  property p_rd_we; !o_ctl.output_en_n |-> o_ctl.write_en_n; endproperty
  a_rd_we: assert property (p_rd_we) else $error("we low in read");
  property p_rd_oe; !o_ctl.output_en_n |-> o_dq_oe == 16'h0000; endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("host drives in read");
  property p_ln; o_ctl.select_active_low && $past(o_ctl.select_active_low) |-> $stable(o_ctl[1:0]); endproperty
  a_ln: assert property (p_ln) else $error("lanes move deselected");
  property p_hold; !o_ctl.write_en_n && $past(!o_ctl.write_en_n) |-> $stable(o_dq_out) && $stable(o_addr); endproperty
  a_hold: assert property (p_hold) else $error("write data moved");
  property p_wdrv; !o_ctl.write_en_n |-> o_dq_oe == {{8{!o_ctl[1]}}, {8{!o_ctl[0]}}}; endproperty
  a_wdrv: assert property (p_wdrv) else $error("write lanes undriven");
  property p_pulse; $fell(o_ctl.write_en_n) |-> ##8 !o_ctl.write_en_n ##1 o_ctl.write_en_n; endproperty
  a_pulse: assert property (p_pulse) else $error("write pulse length");
  property p_lat; tk && !i_req.write |-> ##13 o_rd_valid; endproperty
  a_lat: assert property (p_lat) else $error("read latency");
  property p_adr; tk |=> o_addr == $past(i_req.addr) && !o_ctl.select_active_low; endproperty
  a_adr: assert property (p_adr) else $error("address late");
  c_wr: cover property (tk && i_req.write);
  c_rd: cover property (tk && !i_req.write);
  c_nl: cover property (i_req_valid && o_req_ready && i_req.lanes == 2'h0);
endmodule  // asc_host_checker

//--- testbench.sv
// self-checking bench for the sram host controller
`timescale 1ns/10ps
module testbench;
  import asc_pkg::*;
  logic i_clk = 1'b0, i_rst_b = 1'b0, i_req_valid = 1'b0, o_req_ready, o_rd_valid;
  asc_req_t i_req = '0;
  asc_ctl_t o_ctl;
  logic [ASC_AW-1:0] o_addr;
  logic [ASC_DW-1:0] o_rd_data, o_dq_out, o_dq_oe, m_dq, m_drv, i_dq_in, pat = 16'h0000, rm [16];
  integer n_mismatch = 0, compares = 0, seed = 32'h604b63da, k, r;
  always #2 i_clk = ~i_clk;
  // released lines flip every cycle so stale data cannot pass
  always @(posedge i_clk) pat <= ~pat;
  assign i_dq_in = (o_dq_oe & o_dq_out) | (~o_dq_oe & m_drv & m_dq) | (~o_dq_oe & ~m_drv & pat);
  asc_host i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req_valid(i_req_valid), .i_req(i_req),
    .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_ctl(o_ctl),
    .o_addr(o_addr), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .i_dq_in(i_dq_in));
  asc_sram_model i_mem (.i_clk(i_clk), .i_ctl(o_ctl), .i_addr(o_addr), .i_dq(i_dq_in), .o_dq(m_dq), .o_drv(m_drv));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one request, waits bounded; reads compared with the bench copy
  task automatic access(input logic wr, input logic [1:0] ln, input logic [3:0] a, input logic [15:0] d);
    logic [15:0] m;
    m = {{8{ln[1]}}, {8{ln[0]}}};
    k = 0;
    while (o_req_ready !== 1'b1 && k < 40) begin
      @(posedge i_clk);
      #1 k++;
    end
    i_req_valid = 1'b1;
    i_req = '{wr, {16'h5a3c, a}, ln, d};
    @(posedge i_clk);
    #1 i_req_valid = 1'b0;
    if (ln == 2'h0) begin
      check("idle pins", o_ctl, ASC_CTL_IDLE);
      check("ready", o_req_ready, 1'b1);
      // let an edge pass with valid low before the next request may start
      @(posedge i_clk);
      #1 check("still idle", o_ctl, ASC_CTL_IDLE);
    end else if (wr) rm[a] = (rm[a] & ~m) | (d & m);
    else begin
      while (o_rd_valid !== 1'b1 && k < 80) begin
        @(posedge i_clk);
        #1 k++;
      end
      check("read data", o_rd_data, rm[a] & m);
    end
    if (k >= 40) begin
      check("timeout", 1'b0, 1'b1);
      finish_test();
    end
  endtask
  initial begin
    for (int j = 0; j < 16; j++) rm[j] = 16'h0000;
    repeat (5) @(posedge i_clk);
    #1 i_rst_b = 1'b1;
    access(1'b1, 2'h3, 4'h0, 16'hffff);
    access(1'b1, 2'h2, 4'h0, 16'h1234);
    access(1'b0, 2'h1, 4'h0, 16'h0000);
    access(1'b0, 2'h3, 4'h0, 16'h0000);
    access(1'b1, 2'h0, 4'h1, 16'hbeef);
    for (int n = 0; n < 40; n++) begin
      r = $random(seed);
      access(r[0], r[2:1] == 2'h0 ? 2'h3 : r[2:1], r[6:3], r[22:7]);
    end
    finish_test();
  end
endmodule  // testbench
bind asc_host asc_host_checker i_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req_valid(i_req_valid), .i_req(i_req),
  .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_ctl(o_ctl), .o_addr(o_addr),
  .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .i_dq_in(i_dq_in));
